// ==== capture_pkg.sv ====
// Constants for the input capture channel: register map, fields, reset values, codes
package capture_pkg;
   // Register byte offsets on the APB bus
   localparam logic [7:0] CTRL_ONE_OFFSET = 8'h00;
   localparam logic [7:0] CTRL_TWO_OFFSET = 8'h04;
   localparam logic [7:0] BUF_DATA_OFFSET = 8'h08;
   localparam logic [7:0] TIMER_OFFSET = 8'h0c;
   // Control one field positions
   localparam int IDLE_STOP_POS = 13;
   localparam int TSEL_POS = 10;
   localparam int CPI_POS = 5;
   localparam int OVF_POS = 4;
   localparam int BNE_POS = 3;
   localparam int MODE_POS = 0;
   // Control two field positions
   localparam int CASCADE_POS = 8;
   localparam int TRIG_OP_POS = 7;
   localparam int TRIG_STAT_POS = 6;
   localparam int SYNC_POS = 0;
   // Reset values
   localparam logic [2:0] TSEL_RESET = 3'h0;
   localparam logic [1:0] CPI_RESET = 2'h0;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [4:0] SYNC_RESET = 5'h0d;
   // Capture mode codes
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_BOTH = 3'h1;
   localparam logic [2:0] MODE_FALL = 3'h2;
   localparam logic [2:0] MODE_RISE = 3'h3;
   localparam logic [2:0] MODE_RISE4 = 3'h4;
   localparam logic [2:0] MODE_RISE16 = 3'h5;
   localparam logic [2:0] MODE_UNUSED = 3'h6;
   localparam logic [2:0] MODE_WAKE = 3'h7;
   // Prescaler edge counts
   localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
   localparam logic [3:0] PRESCALE_16_LAST = 4'hf;
   // Timer clock select codes
   localparam logic [2:0] TSEL_T3 = 3'h0;
   localparam logic [2:0] TSEL_T2 = 3'h1;
   localparam logic [2:0] TSEL_T4 = 3'h2;
   localparam logic [2:0] TSEL_T5 = 3'h3;
   localparam logic [2:0] TSEL_T1 = 3'h4;
   localparam logic [2:0] TSEL_PCLK = 3'h7;
   // Positions of timer ticks in the tick input vector
   localparam int TICK_T1 = 0;
   localparam int TICK_T2 = 1;
   localparam int TICK_T3 = 2;
   localparam int TICK_T4 = 3;
   localparam int TICK_T5 = 4;
   // Source select codes that name no source
   localparam logic [4:0] SRC_NONE_LO = 5'h00;
   localparam logic [4:0] SRC_NONE_HI = 5'h1f;
   // Buffer depth
   localparam int BUF_DEPTH = 4;
endpackage

// ==== capture_buffer.sv ====
// Capture value buffer with push, pop, full and empty
module capture_buffer #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Write and read side
   input wire logic i_push,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_pop,
   input wire logic i_flush,
   output logic [WIDTH-1:0] o_data,
   output logic o_full,
   output logic o_empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] count_q;
   logic do_push;
   logic do_pop;

   // Push refused when full, pop refused when empty
   assign do_push = i_push && !o_full;
   assign do_pop = i_pop && !o_empty;
   assign o_full = (count_q == (AW+1)'(DEPTH));
   assign o_empty = (count_q == '0);
   assign o_data = mem_q[rd_q];

   // Storage
   always_ff @(posedge i_ref_clk) begin
      if (do_push) begin
         mem_q[wr_q] <= i_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || i_flush) begin
         wr_q <= '0;
         rd_q <= '0;
         count_q <= '0;
      end else begin
         if (do_push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (do_pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         if (do_push && !do_pop) begin
            count_q <= count_q + 1'b1;
         end else if (do_pop && !do_push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end
endmodule

// ==== input_capture_channel.sv ====
// Input capture channel: edge detect, capture timer, buffer and APB registers
// Overview of operation
// - Idle-stop bit halts channel during Idle
// - Clock select picks the timer tick
// - Interrupt every one to four captures
// - Count ignored in both-edge and wake modes
// - Overflow flag set when buffer overflows
// - Not-empty flag shows unread captures
// - Mode 111: rising-edge wake pin only
// - Prescaler modes: every 4th or 16th rise
// - Simple modes: every rise or fall
// - Mode 001 captures on both edges
// - Modes 000 and 110 disable channel
// - Cascade bit joins odd and even channels
// - Cascade needs bit set in both channels
// - Trigger-select picks trigger or sync operation
// - Trigger status shows running, else timer zero
// - Source sets status; software reads, sets, clears
// - Source select resets to timer three
// - Source codes map to fixed modules
// - Buffer holds four captured values
module input_capture_channel #(
   parameter int TIMER_WIDTH = 16,
   parameter int DEPTH = capture_pkg::BUF_DEPTH,
   parameter bit IS_ODD = 1'b0
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Capture pin and power modes
   input wire logic i_capture_pin,
   input wire logic i_idle_mode,
   input wire logic i_sleep_mode,
   // Timer tick enables, bit 0 timer one up to bit 4 timer five
   input wire logic [4:0] i_timer_tick,
   // Sync and trigger source pulses, indexed by source code
   input wire logic [31:0] i_sync_source,
   // Cascade partner
   input wire logic i_partner_cascade,
   input wire logic i_partner_carry,
   input wire logic i_partner_capture,
   output logic o_cascade_bit,
   output logic o_timer_carry,
   output logic o_capture_event,
   // Channel events
   output logic o_capture_int,
   output logic o_wake
);
   localparam logic [TIMER_WIDTH-1:0] TIMER_MAX = '1;

   // Control fields
   logic idle_stop_bit_q;
   logic [2:0] timer_clock_select_q;
   logic [1:0] captures_per_interrupt_q;
   logic [2:0] capture_mode_field_q;
   logic cascade_enable_bit_q;
   logic trigger_operation_select_q;
   logic trigger_status_bit_q;
   logic [4:0] sync_trigger_source_select_q;
   logic buffer_overflow_flag_q;
   // Datapath state
   logic [TIMER_WIDTH-1:0] capture_timer_q;
   logic pin_q;
   logic [3:0] prescale_q;
   logic [1:0] int_count_q;
   // Decoded strobes
   logic bus_done;
   logic bus_write;
   logic bus_read;
   logic wr_ctrl_one;
   logic wr_ctrl_two;
   logic rd_data;
   logic mode_on;
   logic running;
   logic cascade_active;
   logic tick;
   logic source_pulse;
   logic rise;
   logic fall;
   logic edge_event;
   logic capture;
   logic buf_full;
   logic buf_empty;
   logic [TIMER_WIDTH-1:0] buf_data;
   logic [31:0] ctrl_one_word;
   logic [31:0] ctrl_two_word;

   // Timer tick chosen by the clock select code; reserved codes give none
   function automatic logic pick_tick(input logic [2:0] sel, input logic [4:0] ticks);
      logic t;
      t = 1'b0;
      unique case (sel)
         capture_pkg::TSEL_PCLK: t = 1'b1;
         capture_pkg::TSEL_T1: t = ticks[capture_pkg::TICK_T1];
         capture_pkg::TSEL_T5: t = ticks[capture_pkg::TICK_T5];
         capture_pkg::TSEL_T4: t = ticks[capture_pkg::TICK_T4];
         capture_pkg::TSEL_T2: t = ticks[capture_pkg::TICK_T2];
         capture_pkg::TSEL_T3: t = ticks[capture_pkg::TICK_T3];
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   // Source codes that name a real module
   function automatic logic source_valid(input logic [4:0] code);
      return (code >= 5'h01 && code <= 5'h04) || (code >= 5'h0a && code <= 5'h13) ||
         (code >= 5'h18 && code <= 5'h1c);
   endfunction

   // APB handshake: access answered one cycle after the first access edge
   assign bus_done = i_psel && i_penable && o_pready;
   assign bus_write = bus_done && i_pwrite && !o_pslverr;
   assign bus_read = bus_done && !i_pwrite && !o_pslverr;
   assign wr_ctrl_one = bus_write && (i_paddr == capture_pkg::CTRL_ONE_OFFSET);
   assign wr_ctrl_two = bus_write && (i_paddr == capture_pkg::CTRL_TWO_OFFSET);
   assign rd_data = bus_read && (i_paddr == capture_pkg::BUF_DATA_OFFSET);

   // Mode decode
   assign mode_on = (capture_mode_field_q != capture_pkg::MODE_OFF) &&
      (capture_mode_field_q != capture_pkg::MODE_UNUSED) &&
      (capture_mode_field_q != capture_pkg::MODE_WAKE);
   assign running = mode_on && !(idle_stop_bit_q && i_idle_mode);
   assign cascade_active = cascade_enable_bit_q && i_partner_cascade;
   assign source_pulse = source_valid(sync_trigger_source_select_q) &&
      i_sync_source[sync_trigger_source_select_q];
   assign tick = running && (cascade_active && IS_ODD ? i_partner_carry :
      pick_tick(timer_clock_select_q, i_timer_tick));

   // Edge detection on the pin
   assign rise = i_capture_pin && !pin_q;
   assign fall = !i_capture_pin && pin_q;
   always_comb begin
      edge_event = 1'b0;
      unique case (capture_mode_field_q)
         capture_pkg::MODE_BOTH: edge_event = rise || fall;
         capture_pkg::MODE_FALL: edge_event = fall;
         capture_pkg::MODE_RISE: edge_event = rise;
         capture_pkg::MODE_RISE4: edge_event = rise &&
            (prescale_q[1:0] == capture_pkg::PRESCALE_4_LAST[1:0]);
         capture_pkg::MODE_RISE16: edge_event = rise &&
            (prescale_q == capture_pkg::PRESCALE_16_LAST);
         default: edge_event = 1'b0;
      endcase
   end
   // Odd half of a cascade takes its event from the even half
   assign capture = running &&
      ((cascade_active && IS_ODD) ? i_partner_capture : edge_event);

   // Pin history
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= i_capture_pin;
      end
   end

   // Prescaler counts rising edges while running
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !running) begin
         prescale_q <= '0;
      end else if (rise) begin
         prescale_q <= prescale_q + 4'h1;
      end
   end

   // Capture timer: held clear until triggered, reset by sync pulses
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !mode_on) begin
         capture_timer_q <= '0;
      end else if (trigger_operation_select_q && !trigger_status_bit_q) begin
         capture_timer_q <= '0;
      end else if (!trigger_operation_select_q && source_pulse) begin
         capture_timer_q <= '0;
      end else if (tick) begin
         capture_timer_q <= capture_timer_q + 1'b1;
      end
   end

   // Carry to the odd half of a cascade
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_timer_carry <= 1'b0;
      end else begin
         o_timer_carry <= tick && (capture_timer_q == TIMER_MAX) &&
            !(trigger_operation_select_q && !trigger_status_bit_q);
      end
   end

   // Trigger status: source sets, software writes, set wins
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         trigger_status_bit_q <= 1'b0;
      end else if (trigger_operation_select_q && source_pulse && mode_on) begin
         trigger_status_bit_q <= 1'b1;
      end else if (wr_ctrl_two) begin
         trigger_status_bit_q <= i_pwdata[capture_pkg::TRIG_STAT_POS];
      end
   end

   // Capture buffer
   capture_buffer #(
      .WIDTH(TIMER_WIDTH),
      .DEPTH(DEPTH)
   ) capture_buffer_i (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_push(capture && !buffer_overflow_flag_q),
      .i_data(capture_timer_q),
      .i_pop(rd_data),
      .i_flush(!mode_on),
      .o_data(buf_data),
      .o_full(buf_full),
      .o_empty(buf_empty)
   );

   // Overflow: set on capture into a full buffer, cleared once drained
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         buffer_overflow_flag_q <= 1'b0;
      end else if (capture && buf_full) begin
         buffer_overflow_flag_q <= 1'b1;
      end else if (buf_empty || !mode_on) begin
         buffer_overflow_flag_q <= 1'b0;
      end
   end

   // Captures-per-interrupt counter
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || !running) begin
         int_count_q <= '0;
      end else if (capture) begin
         if (capture_mode_field_q == capture_pkg::MODE_BOTH ||
               int_count_q == captures_per_interrupt_q) begin
            int_count_q <= '0;
         end else begin
            int_count_q <= int_count_q + 2'h1;
         end
      end
   end

   // Capture interrupt and event pulses
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_capture_int <= 1'b0;
         o_capture_event <= 1'b0;
      end else begin
         o_capture_int <= capture && (capture_mode_field_q == capture_pkg::MODE_BOTH ||
            int_count_q == captures_per_interrupt_q);
         o_capture_event <= capture;
      end
   end

   // Wake pulse on rising edge during Sleep or Idle
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= (capture_mode_field_q == capture_pkg::MODE_WAKE) && rise &&
            (i_sleep_mode || i_idle_mode);
      end
   end

   // Control one writable fields
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         idle_stop_bit_q <= 1'b0;
         timer_clock_select_q <= capture_pkg::TSEL_RESET;
         captures_per_interrupt_q <= capture_pkg::CPI_RESET;
         capture_mode_field_q <= capture_pkg::MODE_RESET;
      end else if (wr_ctrl_one) begin
         idle_stop_bit_q <= i_pwdata[capture_pkg::IDLE_STOP_POS];
         timer_clock_select_q <= i_pwdata[capture_pkg::TSEL_POS +: 3];
         captures_per_interrupt_q <= i_pwdata[capture_pkg::CPI_POS +: 2];
         capture_mode_field_q <= i_pwdata[capture_pkg::MODE_POS +: 3];
      end
   end

   // Control two writable fields
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         cascade_enable_bit_q <= 1'b0;
         trigger_operation_select_q <= 1'b0;
         sync_trigger_source_select_q <= capture_pkg::SYNC_RESET;
      end else if (wr_ctrl_two) begin
         cascade_enable_bit_q <= i_pwdata[capture_pkg::CASCADE_POS];
         trigger_operation_select_q <= i_pwdata[capture_pkg::TRIG_OP_POS];
         sync_trigger_source_select_q <= i_pwdata[capture_pkg::SYNC_POS +: 5];
      end
   end

   // Cascade bit shown to the partner channel
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_cascade_bit <= 1'b0;
      end else begin
         o_cascade_bit <= cascade_enable_bit_q;
      end
   end

   // Read words
   always_comb begin
      ctrl_one_word = '0;
      ctrl_one_word[capture_pkg::IDLE_STOP_POS] = idle_stop_bit_q;
      ctrl_one_word[capture_pkg::TSEL_POS +: 3] = timer_clock_select_q;
      ctrl_one_word[capture_pkg::CPI_POS +: 2] = captures_per_interrupt_q;
      ctrl_one_word[capture_pkg::OVF_POS] = buffer_overflow_flag_q;
      ctrl_one_word[capture_pkg::BNE_POS] = !buf_empty;
      ctrl_one_word[capture_pkg::MODE_POS +: 3] = capture_mode_field_q;
      ctrl_two_word = '0;
      ctrl_two_word[capture_pkg::CASCADE_POS] = cascade_enable_bit_q;
      ctrl_two_word[capture_pkg::TRIG_OP_POS] = trigger_operation_select_q;
      ctrl_two_word[capture_pkg::TRIG_STAT_POS] = trigger_status_bit_q;
      ctrl_two_word[capture_pkg::SYNC_POS +: 5] = sync_trigger_source_select_q;
   end

   // APB answer: ready one cycle into the access phase, error on unmapped address
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else if (i_psel && i_penable && !o_pready) begin
         o_pready <= 1'b1;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
         unique case (i_paddr)
            capture_pkg::CTRL_ONE_OFFSET: o_prdata <= ctrl_one_word;
            capture_pkg::CTRL_TWO_OFFSET: o_prdata <= ctrl_two_word;
            capture_pkg::BUF_DATA_OFFSET: o_prdata <= 32'(buf_data);
            capture_pkg::TIMER_OFFSET: o_prdata <= 32'(capture_timer_q);
            default: o_pslverr <= 1'b1;
         endcase
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end
   end
endmodule

// ==== input_capture_channel_properties.sv ====
// Concurrent checks on the capture channel ports
module input_capture_channel_properties (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_capture_pin,
   input wire logic i_idle_mode,
   input wire logic i_sleep_mode,
   input wire logic o_cascade_bit,
   input wire logic o_capture_event,
   input wire logic o_capture_int,
   input wire logic o_wake
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   logic [15:0] ctl_q;
   logic casc_q;
   logic done;
   logic [2:0] md;
   // Completed writes and the mode they leave
   assign done = i_psel && i_penable && o_pready && i_pwrite;
   assign md = ctl_q[2:0];
   // Shadow of control one
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ctl_q <= 16'h0000;
      end else if (done && i_paddr == 8'h00) begin
         ctl_q <= i_pwdata[15:0];
      end
   end
   // Shadow of the cascade bit
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         casc_q <= 1'b0;
      end else if (done && i_paddr == 8'h04) begin
         casc_q <= i_pwdata[8];
      end
   end
   sequence s_access;
      i_psel && i_penable && !o_pready;
   endsequence
   sequence s_idle_held;
      (ctl_q[13] && i_idle_mode) [*3];
   endsequence
   AST_READY_NEXT: assert property (s_access |=> o_pready ##1 !o_pready)
      else $error("pready not a one cycle answer");
   AST_ERR_ZERO: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
      else $error("error answer malformed");
   AST_IDLE_HALT: assert property (s_idle_held |-> !o_capture_event)
      else $error("capture while halted in idle");
   AST_RISE_ONLY: assert property (md inside {3'h3, 3'h4, 3'h5} && $past(md, 2) == md
      && o_capture_event |-> $past(i_capture_pin) && !$past(i_capture_pin, 2))
      else $error("capture without rising edge");
   AST_FALL_ONLY: assert property (md == 3'h2 && $past(md, 2) == md
      && o_capture_event |-> !$past(i_capture_pin) && $past(i_capture_pin, 2))
      else $error("capture without falling edge");
   AST_ANY_EDGE: assert property (md == 3'h1 && $past(md, 2) == md
      && o_capture_event |-> $past(i_capture_pin) != $past(i_capture_pin, 2))
      else $error("capture without edge");
   AST_INT_EACH: assert property ((md == 3'h1 || ctl_q[6:5] == 2'h0) && md != 3'h0
      && md < 3'h6 && o_capture_event |-> o_capture_int)
      else $error("interrupt missing on capture");
   AST_OFF_QUIET: assert property ((md == 3'h0 || md == 3'h6) && $past(md, 2) == md
      |-> !o_capture_event && !o_capture_int)
      else $error("activity while disabled");
   AST_WAKE_RISE: assert property (md == 3'h7 && $past(md, 2) == md
      && (i_sleep_mode || i_idle_mode) && $rose(i_capture_pin) |-> ##[1:2] o_wake)
      else $error("wake pulse missing");
   AST_WAKE_MODE: assert property (o_wake |-> md == 3'h7 || $past(md) == 3'h7)
      else $error("wake outside wake mode");
   AST_CASCADE_COPY: assert property (done && i_paddr == 8'h04
      |-> ##[1:2] o_cascade_bit == casc_q)
      else $error("cascade bit not reflected");
endmodule

bind input_capture_channel input_capture_channel_properties input_capture_channel_properties_i (
   .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_capture_pin(i_capture_pin),
   .i_idle_mode(i_idle_mode), .i_sleep_mode(i_sleep_mode), .o_cascade_bit(o_cascade_bit),
   .o_capture_event(o_capture_event), .o_capture_int(o_capture_int), .o_wake(o_wake));

// ==== capture_source_model.sv ====
// Far side model: capture pin, running timer ticks, source pulses
module capture_source_model (
   input wire logic i_ref_clk,
   input wire logic i_level,
   input wire logic i_fire,
   input wire logic [4:0] i_code,
   output logic o_pin,
   output logic [4:0] o_tick,
   output logic [31:0] o_sync
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // Quiet outputs from time zero
   initial begin
      o_pin = 1'b0;
      o_tick = 5'h00;
      o_sync = 32'h0;
   end
   // Timer n ticks every n+1 cycles and never stops
   always @(posedge i_ref_clk) begin
      cnt <= (cnt + 1) % 60;
      for (int i = 0; i < 5; i++) begin
         o_tick[i] <= (cnt % (i + 2)) == 0;
      end
      o_sync <= i_fire ? (32'h1 << i_code) : 32'h0;
      o_pin <= i_level;
   end
endmodule

// ==== tb_input_capture_channel.sv ====
// Self-checking bench for the capture channel
module tb_input_capture_channel;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rerr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv, sync;
   logic pready, pslverr, pin, lvl = 1'b0, fire = 1'b0, idle = 1'b0, sleep = 1'b0;
   logic casc_o, cint, wake, carry;
   logic [4:0] code = 5'h00, tick;
   logic [2:0] tsel_tab [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h6};
   logic [15:0] gap_tab [7] = '{16'h000f, 16'h0014, 16'h000c, 16'h000a, 16'h001e,
      16'h003c, 16'h0000};
   logic [4:0] src_tab [7] = '{5'h01, 5'h04, 5'h0a, 5'h0b, 5'h10, 5'h18, 5'h1c};
   int err_total = 0, samples_checked = 0, ints = 0, wakes = 0, cyc = 0;
   int wbase = 0, carries = 0, cb = 0;
   // Design and far side
   input_capture_channel input_capture_channel_i (
      .i_ref_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_capture_pin(pin), .i_idle_mode(idle), .i_sleep_mode(sleep),
      .i_timer_tick(tick), .i_sync_source(sync), .i_partner_cascade(1'b0),
      .i_partner_carry(1'b0), .i_partner_capture(1'b0), .o_cascade_bit(casc_o),
      .o_timer_carry(carry), .o_capture_event(), .o_capture_int(cint), .o_wake(wake));
   capture_source_model capture_source_model_i (.i_ref_clk(clk), .i_level(lvl),
      .i_fire(fire), .i_code(code), .o_pin(pin), .o_tick(tick), .o_sync(sync));
   // 100 ns clock
   initial forever #50 clk = ~clk;
   // Event counters and hang limit
   always @(posedge clk) begin
      ints <= ints + (cint === 1'b1);
      wakes <= wakes + (wake === 1'b1);
      carries <= carries + (carry === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         err_total++;
         test_done;
      end
   end
   task automatic test_done;
      if (err_total == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer; read data and error taken at the ready edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic pulse(input logic [4:0] c);
      code <= c;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // Configure, drive n pin pulses, then check flags, interrupts and capture gaps
   task automatic run(input logic [15:0] ctl, input int per, input int n, input int caps,
      input logic [15:0] dif, input int nint);
      logic [15:0] prev;
      int nv;
      int i0;
      nv = caps > 4 ? 4 : caps;
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b1, 8'h00, {16'h0, ctl});
      i0 = ints;
      repeat (n) begin
         lvl <= 1'b1;
         repeat (per / 2) @(posedge clk);
         lvl <= 1'b0;
         repeat (per - per / 2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      xfer(1'b0, 8'h00, 32'h0);
      chk("overflow", 16'(caps > 4), 16'(rv[4]));
      chk("not empty", 16'(nv > 0), 16'(rv[3]));
      if (nint >= 0) chk("interrupts", 16'(nint), 16'(ints - i0));
      for (int i = 0; i < nv; i++) begin
         xfer(1'b0, 8'h08, 32'h0);
         if (i > 0) chk("capture gap", dif, rv[15:0] - prev);
         prev = rv[15:0];
      end
      xfer(1'b0, 8'h00, 32'h0);
      chk("drained", 16'h0000, {14'h0, rv[4:3]});
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b0, 8'h00, 32'h0);
      chk("control one", 16'h0000, rv[15:0]);
      xfer(1'b0, 8'h04, 32'h0);
      chk("control two", 16'h000d, rv[15:0]);
      xfer(1'b0, 8'h10, 32'h0);
      chk("slave error", 16'h0001, {rv[15:1], rerr});
      run(16'h1c03, 10, 3, 3, 16'h000a, 3);
      run(16'h1c02, 10, 3, 3, 16'h000a, 3);
      run(16'h1c61, 10, 2, 4, 16'h0005, 4);
      run(16'h1c04, 10, 8, 2, 16'h0028, 2);
      run(16'h1c05, 10, 32, 2, 16'h00a0, 2);
      run(16'h1c03, 10, 6, 6, 16'h000a, -1);
      run(16'h1c00, 10, 3, 0, 16'h0000, 0);
      run(16'h1c06, 10, 3, 0, 16'h0000, 0);
      foreach (tsel_tab[i]) run({3'h0, tsel_tab[i], 10'h003}, 60, 3, 3, gap_tab[i], 3);
      for (int c = 0; c < 4; c++) run({9'h038, 2'(c), 5'h03}, 10, 4, 4, 16'h000a, 4 / (c + 1));
      idle <= 1'b1;
      run(16'h3c03, 10, 3, 0, 16'h0000, 0);
      run(16'h1c03, 10, 3, 3, 16'h000a, 3);
      sleep <= 1'b1;
      wbase = wakes;
      run(16'h1c07, 10, 3, 0, 16'h0000, -1);
      chk("wake pulses", 16'h0003, 16'(wakes - wbase));
      idle <= 1'b0;
      sleep <= 1'b0;
      xfer(1'b1, 8'h04, 32'h0000010d);
      repeat (2) @(posedge clk);
      chk("cascade bit", 16'h0001, {15'h0, casc_o});
      xfer(1'b1, 8'h04, 32'h0000008b);
      xfer(1'b1, 8'h00, 32'h00001c03);
      xfer(1'b0, 8'h0c, 32'h0);
      chk("timer held", 16'h0000, rv[15:0]);
      foreach (src_tab[i]) begin
         xfer(1'b1, 8'h04, {24'h0, 3'h4, src_tab[i]});
         pulse(src_tab[i]);
         xfer(1'b0, 8'h04, 32'h0);
         chk("source status", {8'h0, 3'h6, src_tab[i]}, rv[15:0]);
      end
      xfer(1'b0, 8'h0c, 32'h0);
      chk("timer running", 16'h0001, 16'(rv[15:0] != 16'h0));
      xfer(1'b1, 8'h04, 32'h0000009f);
      pulse(5'h1f);
      xfer(1'b0, 8'h04, 32'h0);
      chk("no source", 16'h009f, rv[15:0]);
      xfer(1'b1, 8'h04, 32'h000000cb);
      xfer(1'b0, 8'h04, 32'h0);
      chk("status set", 16'h00cb, rv[15:0]);
      xfer(1'b1, 8'h04, 32'h0000000b);
      repeat (60) @(posedge clk);
      pulse(5'h0b);
      xfer(1'b0, 8'h0c, 32'h0);
      chk("sync restart", 16'h0001, 16'(rv[15:0] < 16'h000c));
      // One full timer period gives exactly one carry pulse
      cb = carries;
      repeat (65536) @(posedge clk);
      chk("timer carry", 16'h0001, 16'(carries - cb));
      test_done;
   end
endmodule
